/* hdl/aac_action_unit.sv */
// ACL action stage with per-entry count mode and per-port interrupt flag
`timescale 1ns/1ps
// Behaviour
// - Priority mode 00 keeps QoS, 01 takes rule priority if larger, 10 if smaller, 11 always.
// - With remark enabled the PCP bits become the remarked value, otherwise untouched.
// - Map mode 00 keeps lookup map, 01 ORs, 10 ANDs, 11 replaces it with the rule map.
// - Rule map bit i stands for port i+1, 1 forwards and 0 blocks.
// - Counter algorithm 0 raises the interrupt when the down-counter expires.
// - Tick unit bit 0 selects microseconds, 1 selects milliseconds.
// - Counter algorithm 1 counts matches, interrupts at terminal count, then restarts.
// - The table holds 16 entries of matching, action and process fields.
// - Fields of an entry are independent except in count mode, where match and action work jointly.
// - Filtering actions never interrupt; only count-mode entries do.
// - Count mode counts or times packets matching a MAC address with an EtherType.
// - Each port has a status flag and mask feeding a top-level status and mask pair.
// - Rule processing is enabled by the port's authentication control enable.
// - Mode 00 disables, 01 layer 2 or counter, 10 layer 3, 11 layer 4.
// - In count mode the 11-bit count comes from the priority, remark and map field positions.
module aac_action_unit
  import aac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic acl_enable,
  input wire logic tbl_wr,
  input wire logic [AAC_IDX_W-1:0] tbl_idx,
  input wire aac_entry_t tbl_wdata,
  output aac_entry_t tbl_rdata,
  input wire logic pkt_valid,
  input wire logic pkt_hit,
  input wire logic [AAC_IDX_W-1:0] pkt_rule,
  input wire logic [47:0] pkt_mac,
  input wire logic [15:0] pkt_type,
  input wire logic [2:0] qos_priority,
  input wire logic [2:0] pkt_pcp,
  input wire logic [AAC_PORTS-1:0] lookup_map,
  output logic res_valid,
  output aac_result_t res,
  input wire logic int_clear,
  input wire logic port_int_mask,
  input wire logic glob_int_mask,
  output logic port_int_status,
  output logic glob_int_status,
  output logic int_out
);
  // ------------------------------------------------------------
  // Rule table and per-entry counters
  // ------------------------------------------------------------
  aac_entry_t table_q [AAC_ENTRIES];
  logic [AAC_CNT_W-1:0] cnt_q [AAC_ENTRIES];
  logic [AAC_ENTRIES-1:0] run_q;
  logic [AAC_ENTRIES-1:0] fire;
  logic us_tick;
  logic ms_tick;
  aac_entry_t hit_e;
  aac_result_t res_d;
  logic [2:0] prio_d;
  logic hit_count;

  aac_tick_gen u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .us_tick(us_tick),
    .ms_tick(ms_tick)
  );

  // Table write port and registered readback
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tbl_rdata <= '0;
    end else if (clk_en) begin
      if (tbl_wr) begin
        table_q[tbl_idx] <= tbl_wdata;
      end
      tbl_rdata <= table_q[tbl_idx];
    end
  end

  // Count-mode decode and count field assembly
  function automatic logic is_count(input aac_entry_t e);
    return (e.match.match_rule_mode == AAC_MD_L2) &&
           (e.match.match_compare_select == AAC_ENB_COUNT);
  endfunction

  // Count bits reuse the priority, remark and map positions
  function automatic logic [AAC_CNT_W-1:0] count_of(input aac_entry_t e);
    return {e.action.priority_select_mode, e.action.rule_priority, e.action.remark_enable,
            e.action.remarked_priority_value, e.action.port_map_merge_mode};
  endfunction

  // ------------------------------------------------------------
  // Per-entry counters
  // ------------------------------------------------------------
  // A table write restarts the entry so stale counts never leak into a new rule
  for (genvar i = 0; i < AAC_ENTRIES; i++) begin : g_cnt
    logic qual;
    logic tick;
    assign qual = pkt_valid && acl_enable && is_count(table_q[i]) &&
                  (pkt_mac == table_q[i].match.mac_addr) &&
                  (pkt_type == table_q[i].match.ether_type);
    assign tick = table_q[i].action.tick_unit_select ? ms_tick : us_tick;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cnt_q[i] <= AAC_CNT_RST;
        run_q[i] <= 1'b0;
        fire[i] <= 1'b0;
      end else if (clk_en) begin
        fire[i] <= 1'b0;
        if (tbl_wr && tbl_idx == AAC_IDX_W'(i)) begin
          cnt_q[i] <= AAC_CNT_RST;
          run_q[i] <= 1'b0;
        end else if (!is_count(table_q[i]) || !acl_enable) begin
          run_q[i] <= 1'b0;
        end else if (!table_q[i].action.counter_algorithm) begin
          if (qual) begin
            cnt_q[i] <= count_of(table_q[i]);
            run_q[i] <= 1'b1;
          end else if (run_q[i] && tick) begin
            if (cnt_q[i] <= 11'h001) begin
              cnt_q[i] <= AAC_CNT_RST;
              run_q[i] <= 1'b0;
              fire[i] <= 1'b1;
            end else begin
              cnt_q[i] <= cnt_q[i] - 1'b1;
            end
          end
        end else if (qual) begin
          // Terminal count is the programmed value; zero is treated as full range
          if (cnt_q[i] + 1'b1 == count_of(table_q[i])) begin
            cnt_q[i] <= AAC_CNT_RST;
            fire[i] <= 1'b1;
          end else begin
            cnt_q[i] <= cnt_q[i] + 1'b1;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Action on the hit entry
  // ------------------------------------------------------------
  assign hit_e = table_q[pkt_rule];
  assign hit_count = is_count(hit_e);

  // Priority selection, unsigned compare
  always_comb begin
    prio_d = qos_priority;
    case (hit_e.action.priority_select_mode)
      AAC_PM_QOS: prio_d = qos_priority;
      AAC_PM_LARGER: prio_d = (hit_e.action.rule_priority > qos_priority) ? hit_e.action.rule_priority
                                                                         : qos_priority;
      AAC_PM_SMALLER: prio_d = (hit_e.action.rule_priority < qos_priority) ? hit_e.action.rule_priority
                                                                          : qos_priority;
      AAC_PM_ALWAYS: prio_d = hit_e.action.rule_priority;
      default: prio_d = qos_priority;
    endcase
  end

  // Result assembly; disabled, missed or count-mode rules pass through
  always_comb begin
    res_d.pkt_priority = qos_priority;
    res_d.remark = 1'b0;
    res_d.pcp = pkt_pcp;
    res_d.fwd_map = lookup_map;
    if (acl_enable && pkt_hit && !hit_count &&
        hit_e.match.match_rule_mode != AAC_MD_OFF) begin
      res_d.pkt_priority = prio_d;
      if (hit_e.action.remark_enable) begin
        res_d.remark = 1'b1;
        res_d.pcp = hit_e.action.remarked_priority_value;
      end
      // Bit i of both maps is port i+1
      case (hit_e.action.port_map_merge_mode)
        AAC_MM_KEEP: res_d.fwd_map = lookup_map;
        AAC_MM_OR: res_d.fwd_map = lookup_map | hit_e.action.port_map;
        AAC_MM_AND: res_d.fwd_map = lookup_map & hit_e.action.port_map;
        AAC_MM_REPLACE: res_d.fwd_map = hit_e.action.port_map;
        default: res_d.fwd_map = lookup_map;
      endcase
    end
  end

  // Result register, one cycle after the packet strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res <= '0;
    end else if (clk_en) begin
      res_valid <= pkt_valid;
      if (pkt_valid) begin
        res <= res_d;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt flags: set wins over clear
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_int_status <= 1'b0;
      glob_int_status <= 1'b0;
      int_out <= 1'b0;
    end else if (clk_en) begin
      port_int_status <= (|fire) | (port_int_status & ~int_clear);
      glob_int_status <= port_int_status & port_int_mask;
      int_out <= glob_int_status & glob_int_mask;
    end
  end
endmodule // aac_action_unit

/* hdl/aac_pkg.sv */
// Package: constants and carrier types for the ACL action and count unit
package aac_pkg;
  // ------------------------------------------------------------
  // Table and field sizes
  // ------------------------------------------------------------
  localparam int AAC_ENTRIES = 16;
  localparam int AAC_IDX_W = 4;
  localparam int AAC_PORTS = 6;
  localparam int AAC_CNT_W = 11;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  localparam logic [1:0] AAC_PM_QOS = 2'h0;
  localparam logic [1:0] AAC_PM_LARGER = 2'h1;
  localparam logic [1:0] AAC_PM_SMALLER = 2'h2;
  localparam logic [1:0] AAC_PM_ALWAYS = 2'h3;
  localparam logic [1:0] AAC_MM_KEEP = 2'h0;
  localparam logic [1:0] AAC_MM_OR = 2'h1;
  localparam logic [1:0] AAC_MM_AND = 2'h2;
  localparam logic [1:0] AAC_MM_REPLACE = 2'h3;
  localparam logic [1:0] AAC_MD_OFF = 2'h0;
  localparam logic [1:0] AAC_MD_L2 = 2'h1;
  localparam logic [1:0] AAC_MD_L3 = 2'h2;
  localparam logic [1:0] AAC_MD_L4 = 2'h3;
  localparam logic [1:0] AAC_ENB_COUNT = 2'h0;

  // ------------------------------------------------------------
  // Timing: tick periods from a 100 MHz clock
  // ------------------------------------------------------------
  localparam int AAC_CLK_MHZ = 100;
  localparam int AAC_US_NS = 1000;
  localparam int AAC_CLK_NS = 10;
  localparam int AAC_US_CYCLES = AAC_US_NS / AAC_CLK_NS;
  localparam int AAC_MS_PER_US = 1000;
  localparam int AAC_TICK_W = 7;
  localparam int AAC_MSDIV_W = 10;

  // ------------------------------------------------------------
  // Reset and terminal count values
  // ------------------------------------------------------------
  localparam logic [AAC_CNT_W-1:0] AAC_CNT_RST = 11'h000;
  localparam logic [AAC_CNT_W-1:0] AAC_CNT_TERM = 11'h7FF;

  // One table entry: matching, action and process fields
  typedef struct packed {
    logic [1:0] match_rule_mode;
    logic [1:0] match_compare_select;
    logic [47:0] mac_addr;
    logic [15:0] ether_type;
  } aac_match_t;

  typedef struct packed {
    logic [1:0] priority_select_mode;
    logic [2:0] rule_priority;
    logic remark_enable;
    logic [2:0] remarked_priority_value;
    logic [1:0] port_map_merge_mode;
    logic tick_unit_select;
    logic counter_algorithm;
    logic [AAC_PORTS-1:0] port_map;
  } aac_action_t;

  typedef struct packed {
    aac_match_t match;
    aac_action_t action;
    logic [15:0] process;
  } aac_entry_t;

  // Result handed to the forwarding engine
  typedef struct packed {
    logic [2:0] pkt_priority;
    logic remark;
    logic [2:0] pcp;
    logic [AAC_PORTS-1:0] fwd_map;
  } aac_result_t;
endpackage

/* hdl/aac_tick_gen.sv */
// Tick generator: one-cycle microsecond and millisecond strobes
`timescale 1ns/1ps
module aac_tick_gen
  import aac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  output logic us_tick,
  output logic ms_tick
);
  logic [AAC_TICK_W-1:0] us_div_q;
  logic [AAC_MSDIV_W-1:0] ms_div_q;
  localparam logic [AAC_TICK_W-1:0] US_LAST = AAC_TICK_W'(AAC_US_CYCLES - 1);
  localparam logic [AAC_MSDIV_W-1:0] MS_LAST = AAC_MSDIV_W'(AAC_MS_PER_US - 1);

  // ------------------------------------------------------------
  // Divider chain; ms strobe coincides with a us strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      us_div_q <= '0;
      ms_div_q <= '0;
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
    end else if (clk_en) begin
      us_tick <= (us_div_q == US_LAST);
      ms_tick <= (us_div_q == US_LAST) && (ms_div_q == MS_LAST);
      if (us_div_q == US_LAST) begin
        us_div_q <= '0;
        ms_div_q <= (ms_div_q == MS_LAST) ? '0 : ms_div_q + 1'b1;
      end else begin
        us_div_q <= us_div_q + 1'b1;
      end
    end
  end
endmodule // aac_tick_gen

/* tb/aac_action_unit_monitor.sv */
// Port checker for the ACL action and count unit
`timescale 1ns/1ps
module aac_action_monitor
  import aac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic acl_enable,
  input wire logic pkt_valid,
  input wire logic [2:0] qos_priority,
  input wire logic [2:0] pkt_pcp,
  input wire logic [AAC_PORTS-1:0] lookup_map,
  input wire logic res_valid,
  input wire aac_result_t res,
  input wire logic int_clear,
  input wire logic port_int_mask,
  input wire logic glob_int_mask,
  input wire logic port_int_status,
  input wire logic glob_int_status,
  input wire logic int_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Fresh result: pulse whose cause was taken at the last running edge
  sequence s_taken; pkt_valid && clk_en; endsequence
  sequence s_fresh; res_valid && $past(clk_en) && $past(rst_n); endsequence
  sequence s_chain; port_int_status && port_int_mask && clk_en ##1 glob_int_mask && clk_en; endsequence
  a_res_latency: assert property (s_taken |=> res_valid)
    else $error("result pulse missing");
  a_pcp_kept: assert property (s_fresh and !res.remark |-> res.pcp == $past(pkt_pcp))
    else $error("pcp altered without remark");
  a_acl_off: assert property (s_fresh and !$past(acl_enable) |->
    res.fwd_map == $past(lookup_map) && res.pkt_priority == $past(qos_priority) && !res.remark)
    else $error("disabled unit altered result");
  // Past-value checks skip the edge right after a reset
  a_glob_follow: assert property ($past(clk_en) && $past(rst_n) |->
    glob_int_status == $past(port_int_status && port_int_mask))
    else $error("global status wrong");
  a_int_follow: assert property ($past(clk_en) && $past(rst_n) |->
    int_out == $past(glob_int_status && glob_int_mask))
    else $error("interrupt output wrong");
  a_int_chain: assert property (s_chain |=> int_out)
    else $error("interrupt chain broken");
  a_int_needs_acl: assert property ($rose(port_int_status) |-> $past(acl_enable && clk_en))
    else $error("interrupt while disabled");
  a_clear_only: assert property ($fell(port_int_status) && $past(rst_n) |-> $past(int_clear && clk_en))
    else $error("status dropped without clear");
  a_hold_frozen: assert property (!clk_en |=> $stable(res) && $stable(port_int_status))
    else $error("state moved while frozen");
endmodule // aac_action_monitor
bind aac_action_unit aac_action_monitor u_mon (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
  .acl_enable(acl_enable), .pkt_valid(pkt_valid), .qos_priority(qos_priority), .pkt_pcp(pkt_pcp),
  .lookup_map(lookup_map), .res_valid(res_valid), .res(res), .int_clear(int_clear),
  .port_int_mask(port_int_mask), .glob_int_mask(glob_int_mask), .port_int_status(port_int_status),
  .glob_int_status(glob_int_status), .int_out(int_out));

/* tb/aac_lookup_model.sv */
// Lookup and classification model that feeds packets to the action unit
`timescale 1ns/1ps
module aac_lookup_model
  import aac_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] rule,
  input wire logic [47:0] mac,
  input wire logic [15:0] typ,
  output logic pkt_valid,
  output logic pkt_hit,
  output logic [3:0] pkt_rule,
  output logic [47:0] pkt_mac,
  output logic [15:0] pkt_type,
  output logic [2:0] qos_priority,
  output logic [2:0] pkt_pcp,
  output logic [AAC_PORTS-1:0] lookup_map
);
  initial begin
    {pkt_valid, pkt_hit, pkt_rule, pkt_mac, pkt_type, qos_priority, pkt_pcp, lookup_map} = '0;
  end
  // One packet per request; fields toggle between packets so stale data never looks valid
  always @(posedge clk) begin
    pkt_valid <= go;
    if (go) begin
      // A quarter of the packets miss in the lookup, so the pass-through path is exercised
      pkt_hit <= ($urandom % 4) != 0;
      {pkt_rule, pkt_mac, pkt_type} <= {rule, mac, typ};
      {qos_priority, pkt_pcp, lookup_map} <= 12'($urandom);
    end else begin
      {pkt_rule, pkt_mac, pkt_type, qos_priority, pkt_pcp, lookup_map} <=
        ~{pkt_rule, pkt_mac, pkt_type, qos_priority, pkt_pcp, lookup_map};
    end
  end
endmodule // aac_lookup_model

/* tb/testbench.sv */
// Self-checking bench for the ACL action and count unit
`timescale 1ns/1ps
module testbench;
  import aac_pkg::*;
  logic clk = 0, rst_n = 0, clk_en = 1, acl_enable = 1, tbl_wr = 0, go = 0, int_clear = 0;
  logic port_int_mask = 1, glob_int_mask = 1, pkt_valid, pkt_hit, res_valid, port_int_status, glob_int_status, int_out;
  logic [3:0] tbl_idx = 0, rule = 0, pkt_rule;
  logic [47:0] mac = 48'h0A0B0C0D0E0F, pkt_mac;
  logic [15:0] typ = 16'h88B5, pkt_type;
  logic [2:0] qos_priority, pkt_pcp;
  logic [AAC_PORTS-1:0] lookup_map;
  aac_entry_t tbl_wdata = '0, tbl_rdata, e;
  aac_entry_t ent [16];
  aac_result_t res;
  int n_mismatch = 0, n_tests = 0;
  initial forever #5 clk = ~clk;
  aac_action_unit dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .acl_enable(acl_enable), .tbl_wr(tbl_wr),
    .tbl_idx(tbl_idx), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .pkt_valid(pkt_valid), .pkt_hit(pkt_hit),
    .pkt_rule(pkt_rule), .pkt_mac(pkt_mac), .pkt_type(pkt_type), .qos_priority(qos_priority), .pkt_pcp(pkt_pcp),
    .lookup_map(lookup_map), .res_valid(res_valid), .res(res), .int_clear(int_clear),
    .port_int_mask(port_int_mask), .glob_int_mask(glob_int_mask), .port_int_status(port_int_status),
    .glob_int_status(glob_int_status), .int_out(int_out));
  aac_lookup_model u_far (.clk(clk), .go(go), .rule(rule), .mac(mac), .typ(typ), .pkt_valid(pkt_valid),
    .pkt_hit(pkt_hit), .pkt_rule(pkt_rule), .pkt_mac(pkt_mac), .pkt_type(pkt_type),
    .qos_priority(qos_priority), .pkt_pcp(pkt_pcp), .lookup_map(lookup_map));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [102:0] got, input logic [102:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Count-mode entries and a disabled unit give the lookup result untouched
  function automatic aac_result_t exp_res(aac_entry_t x, logic en, logic h, logic [2:0] q, logic [2:0] p,
                                          logic [5:0] lm);
    aac_action_t a;
    aac_result_t r;
    a = x.action;
    r = {q, 1'b0, p, lm};
    if (en && h && x.match.match_rule_mode != AAC_MD_OFF &&
        !(x.match.match_rule_mode == AAC_MD_L2 && x.match.match_compare_select == AAC_ENB_COUNT)) begin
      case (a.priority_select_mode)
        AAC_PM_LARGER: if (a.rule_priority > q) r.pkt_priority = a.rule_priority;
        AAC_PM_SMALLER: if (a.rule_priority < q) r.pkt_priority = a.rule_priority;
        AAC_PM_ALWAYS: r.pkt_priority = a.rule_priority;
        default: ;
      endcase
      r.remark = a.remark_enable;
      if (a.remark_enable) r.pcp = a.remarked_priority_value;
      case (a.port_map_merge_mode)
        AAC_MM_OR: r.fwd_map = lm | a.port_map;
        AAC_MM_AND: r.fwd_map = lm & a.port_map;
        AAC_MM_REPLACE: r.fwd_map = a.port_map;
        default: ;
      endcase
    end
    return r;
  endfunction
  task automatic wr(input int i, input aac_entry_t x);
    @(posedge clk);
    tbl_wr <= 1;
    tbl_idx <= i[3:0];
    tbl_wdata <= x;
    @(posedge clk);
    tbl_wr <= 0;
    ent[i] = x;
  endtask
  task automatic send(input int i);
    aac_result_t r;
    @(posedge clk);
    go <= 1;
    rule <= i[3:0];
    @(posedge clk);
    go <= 0;
    #1 r = exp_res(ent[i], acl_enable, pkt_hit, qos_priority, pkt_pcp, lookup_map);
    @(posedge clk);
    #1 chk(103'({res_valid, res}), 103'({1'b1, r}));
  endtask
  // Waits a bounded span for the port flag, then clears it
  task automatic flag_then_clear(input int n);
    for (int k = 0; k < n && port_int_status !== 1'b1; k++) @(posedge clk);
    #1 chk(103'(port_int_status), 103'h1);
    @(posedge clk);
    int_clear <= 1;
    #1 chk(103'({glob_int_status, int_out}), 103'h3);
    @(posedge clk);
    int_clear <= 0;
    #1 chk(103'(port_int_status), 103'h0);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h1D26));
    repeat (8) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 16; i++) begin
      e = 103'({$urandom, $urandom, $urandom, $urandom});
      e.match.match_rule_mode = (i == 5) ? AAC_MD_OFF : AAC_MD_L3;
      e.action.priority_select_mode = 2'(i);
      e.action.port_map_merge_mode = 2'(i >> 2);
      wr(i, e);
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      tbl_idx <= 4'(i);
      repeat (2) @(posedge clk);
      #1 chk(103'(tbl_rdata), 103'(ent[i]));
    end
    for (int k = 0; k < 40; k++) begin
      port_int_mask <= 1'($urandom);
      glob_int_mask <= 1'($urandom);
      acl_enable <= (k % 9 != 4);
      send($urandom % 16);
    end
    clk_en <= 0;
    repeat (5) @(posedge clk);
    {clk_en, acl_enable, port_int_mask, glob_int_mask} <= 4'hF;
    #1 chk(103'(port_int_status), 103'h0);
    e.match = {AAC_MD_L2, AAC_ENB_COUNT, mac, typ};
    e.action = {11'h003, 1'b0, 1'b1, 6'h00};
    wr(13, e);
    repeat (2) send(13);
    chk(103'(port_int_status), 103'h0);
    send(13);
    flag_then_clear(4);
    e.action = {11'h002, 1'b0, 1'b0, 6'h00};
    wr(14, e);
    send(14);
    repeat (90) @(posedge clk);
    #1 chk(103'(port_int_status), 103'h0);
    flag_then_clear(250);
    e.action = {11'h002, 1'b1, 1'b0, 6'h00};
    wr(14, e);
    send(14);
    repeat (300) @(posedge clk);
    #1 chk(103'(port_int_status), 103'h0);
    tally_and_finish();
  end
  // Watchdog sized well beyond the fewer than a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule // testbench
